// [src/ocrg_pkg.sv]
/*
 * ocrg_pkg: constants for the output clock route and gate block.
 * assumes a single 200 MHz system clock and an 8-bit register port
 * addressed by 16-bit register offsets.
 */
`default_nettype none
package ocrg_pkg;

    localparam int NUM_DRV = 10;
    localparam int NUM_SYNTH = 5;

    // per-driver register offsets
    localparam logic [15:0] GATE_OFS [NUM_DRV] = '{
        16'h0108, 16'h010d, 16'h0112, 16'h0117, 16'h011c,
        16'h0121, 16'h0126, 16'h012b, 16'h0130, 16'h013a};
    localparam logic [15:0] CFG_OFS [NUM_DRV] = '{
        16'h0109, 16'h010e, 16'h0113, 16'h0118, 16'h011d,
        16'h0122, 16'h0127, 16'h012c, 16'h0131, 16'h013b};
    localparam logic [15:0] SEL_OFS [NUM_DRV] = '{
        16'h010b, 16'h0110, 16'h0115, 16'h011a, 16'h011f,
        16'h0124, 16'h0129, 16'h012e, 16'h0133, 16'h013d};

    // global registers
    localparam logic [15:0] GLOBAL_GATE_OFS = 16'h0102;
    localparam logic [15:0] ZERO_DELAY_OFS = 16'h091c;
    localparam logic [15:0] RESET_CTRL_OFS = 16'h001e;
    localparam logic [15:0] STATUS_LO_OFS = 16'h0c00;
    localparam logic [15:0] STATUS_HI_OFS = 16'h0c01;

    // field positions
    localparam int GLOBAL_GATE_BIT = 0;
    localparam int PER_DRV_GATE_BIT = 1;
    localparam int GLITCHLESS_BIT = 3;
    localparam int DIS_LVL_LSB = 4;
    localparam int HARD_RESET_BIT = 1;

    // reset values
    localparam logic [7:0] GATE_RST = 8'h02;
    localparam logic [7:0] CFG_RST = 8'h08;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [7:0] GLOBAL_GATE_RST = 8'h01;
    localparam logic [2:0] ZERO_DELAY_RST = 3'h4;

    // field encodings
    localparam logic [2:0] ZD_ON = 3'h3;
    localparam logic [2:0] ZD_NORMAL = 3'h4;
    localparam logic [2:0] SEL_LAST = 3'h4;
    localparam logic [1:0] DIS_LOW = 2'h0;
    localparam logic [1:0] DIS_HIGH = 2'h1;

    // timing
    localparam int CLK_KHZ = 200000;
    localparam int ZD_RESET_DELAY_MS = 750;
    localparam int ZD_RESET_DELAY_CYC = ZD_RESET_DELAY_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        RST_IDLE = 3'b001,
        RST_WAIT = 3'b010,
        RST_FIRE = 3'b100
    } ocrg_rst_state_t;

endpackage
`default_nettype wire

// [src/ocrg_gate.sv]
/*
 * ocrg_gate: one output driver with its own fixed post-divider and gate.
 * assumes src_lvl is already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module ocrg_gate (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic src_lvl,
    input wire logic src_ok,
    input wire logic en_req,
    input wire logic sync_mode,
    input wire logic [1:0] dis_lvl,
    output logic drv_out,
    output logic active
);
    logic src_prev_q;
    logic div_q;
    logic div_d;
    logic active_q;
    logic active_d;
    logic out_q;
    logic out_d;
    logic rise;
    logic boundary;
    logic idle_lvl;

    assign rise = src_ok & src_lvl & ~src_prev_q;
    // post-divider divides the selected source by two
    assign div_d = rise ? ~div_q : div_q; // RQ7
    // period ends when div falls, starts when it rises
    assign boundary = rise & (div_q == active_q);
    assign idle_lvl = (dis_lvl == ocrg_pkg::DIS_HIGH); // RQ16

    always_comb begin
        active_d = active_q;
        if (!sync_mode) begin
            active_d = en_req; // RQ2 RQ5
        end else if (en_req != active_q && (boundary || !src_ok)) begin
            // no source: no period to wait for, so switch at once
            active_d = en_req; // RQ1 RQ3 RQ18
        end
    end

    assign out_d = active_d ? div_d : idle_lvl;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            src_prev_q <= 1'b0;
            div_q <= 1'b0;
            active_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
            div_q <= div_d;
            active_q <= active_d;
            out_q <= out_d;
        end
    end

    assign drv_out = out_q;
    assign active = active_q;
endmodule
`default_nettype wire

// [src/ocrg_top.sv]
/*
 * ocrg_top: output clock crosspoint, per-driver gating, zero-delay
 * feedback selection and hard reset hold-off.
 * assumes synth clocks, pins and feedback are asynchronous to clk_sys;
 * register port is a single-cycle write/read strobe on clk_sys.
 */
//
// Function
// RQ1 - sync disable waits for period end
// RQ2 - async disable turns off at once
// RQ3 - glitchless bit gives runt-free on/off
// RQ4 - glitchless bit resets to one
// RQ5 - glitchless bit zero gives async gating
// RQ6 - any divider feeds any output
// RQ7 - each driver owns a fixed post-divider
// RQ8 - three-bit field picks divider zero..four
// RQ9 - zero-delay takes external feedback
// RQ10 - zero-delay delays hard reset ~750 ms
// RQ11 - host waits out reset delay before writes
// RQ12 - host avoids zero-delay below 128 kHz
// RQ13 - select value three zero-delay, four normal
// RQ14 - global gate zero disables all drivers
// RQ15 - per-driver gate zero disables that driver
// RQ16 - two-bit field picks disabled level
// RQ17 - values five..seven leave driver sourceless
// RQ18 - sync enable starts at period boundary
`timescale 1ns/1ps
`default_nettype none
module ocrg_top #(
    parameter int HARD_RESET_DELAY_CYC = ocrg_pkg::ZD_RESET_DELAY_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] synth_clk,
    input wire logic hard_reset_pin_n,
    input wire logic output_disable_pin,
    input wire logic external_feedback_input,
    input wire logic internal_feedback,
    output logic [9:0] drv_out,
    output logic loop_feedback,
    output logic feedback_external_sel,
    output logic hard_reset_exec
);
    localparam int ND = ocrg_pkg::NUM_DRV;
    localparam int NS = ocrg_pkg::NUM_SYNTH;

    // register storage
    logic [7:0] gate_q [ND];
    logic [7:0] cfg_q [ND];
    logic [7:0] sel_q [ND];
    logic global_gate_q;
    logic [2:0] zd_sel_q;

    // synchronisers, first stage read only by second stage
    logic [NS-1:0] synth_s1_q;
    logic [NS-1:0] synth_s2_q;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic rst_pin_prev_q;
    logic rst_pin_lvl;
    logic oe_pin_lvl;
    logic fb_ext_lvl;
    // padded so a reserved code never indexes past the last source
    logic [7:0] synth_pad;

    // hard reset sequencing
    ocrg_pkg::ocrg_rst_state_t rst_state_q;
    ocrg_pkg::ocrg_rst_state_t rst_state_d;
    logic [27:0] rst_cnt_q;
    logic [27:0] rst_cnt_d;
    logic exec_q;
    logic reset_req;
    logic pin_req;
    logic reg_req;
    logic zd_active;
    logic regs_clear;

    // outputs of the read path and feedback
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic fb_q;
    logic fb_sel_q;

    // per-driver decode and gating
    logic [ND-1:0] gate_hit;
    logic [ND-1:0] cfg_hit;
    logic [ND-1:0] sel_hit;
    logic [ND-1:0] drv_src_lvl;
    logic [ND-1:0] drv_src_ok;
    logic [ND-1:0] drv_en;
    logic [ND-1:0] drv_active;
    logic global_hit;
    logic zd_hit;
    logic rst_hit;
    logic stat_lo_hit;
    logic stat_hi_hit;

    // pins reset to their idle levels so no false request follows reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            synth_s1_q <= '0;
            synth_s2_q <= '0;
            pin_s1_q <= 3'h1;
            pin_s2_q <= 3'h1;
        end else begin
            synth_s1_q <= synth_clk;
            synth_s2_q <= synth_s1_q;
            pin_s1_q <= {external_feedback_input, output_disable_pin, hard_reset_pin_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign rst_pin_lvl = pin_s2_q[0];
    assign oe_pin_lvl = pin_s2_q[1];
    assign fb_ext_lvl = pin_s2_q[2];
    assign synth_pad = {3'h0, synth_s2_q};

    // address decode
    assign global_hit = (reg_addr == ocrg_pkg::GLOBAL_GATE_OFS);
    assign zd_hit = (reg_addr == ocrg_pkg::ZERO_DELAY_OFS);
    assign rst_hit = (reg_addr == ocrg_pkg::RESET_CTRL_OFS);
    assign stat_lo_hit = (reg_addr == ocrg_pkg::STATUS_LO_OFS);
    assign stat_hi_hit = (reg_addr == ocrg_pkg::STATUS_HI_OFS);

    assign zd_active = (zd_sel_q == ocrg_pkg::ZD_ON); // RQ13
    // reload of the register file on an executed hard reset
    assign regs_clear = !nrst || exec_q; // RQ11

    genvar gi;
    generate
        for (gi = 0; gi < ND; gi++) begin : g_drv
            logic [2:0] src_idx;
            assign gate_hit[gi] = (reg_addr == ocrg_pkg::GATE_OFS[gi]);
            assign cfg_hit[gi] = (reg_addr == ocrg_pkg::CFG_OFS[gi]);
            assign sel_hit[gi] = (reg_addr == ocrg_pkg::SEL_OFS[gi]);
            assign src_idx = sel_q[gi][2:0]; // RQ8
            // reserved codes leave the driver without a clock
            assign drv_src_ok[gi] = (src_idx <= ocrg_pkg::SEL_LAST); // RQ17
            assign drv_src_lvl[gi] = drv_src_ok[gi] ? synth_pad[src_idx] : 1'b0; // RQ6
            assign drv_en[gi] = global_gate_q // RQ14
                & gate_q[gi][ocrg_pkg::PER_DRV_GATE_BIT] // RQ15
                & ~oe_pin_lvl;

            ocrg_gate u_gate (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .src_lvl(drv_src_lvl[gi]),
                .src_ok(drv_src_ok[gi]),
                .en_req(drv_en[gi]),
                .sync_mode(cfg_q[gi][ocrg_pkg::GLITCHLESS_BIT]), // RQ3 RQ5
                .dis_lvl(cfg_q[gi][ocrg_pkg::DIS_LVL_LSB +: 2]), // RQ16
                .drv_out(drv_out[gi]),
                .active(drv_active[gi])
            );
        end
    endgenerate

    // register writes
    // an executed hard reset wins over a write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (regs_clear) begin
            for (int i = 0; i < ND; i++) begin
                gate_q[i] <= ocrg_pkg::GATE_RST;
                cfg_q[i] <= ocrg_pkg::CFG_RST; // RQ4
                sel_q[i] <= ocrg_pkg::SEL_RST;
            end
            global_gate_q <= ocrg_pkg::GLOBAL_GATE_RST[0];
            zd_sel_q <= ocrg_pkg::ZERO_DELAY_RST;
        end else if (reg_wr) begin
            for (int i = 0; i < ND; i++) begin
                if (gate_hit[i]) begin
                    gate_q[i] <= reg_wdata;
                end
                if (cfg_hit[i]) begin
                    cfg_q[i] <= reg_wdata;
                end
                if (sel_hit[i]) begin
                    sel_q[i] <= reg_wdata;
                end
            end
            if (global_hit) begin
                global_gate_q <= reg_wdata[ocrg_pkg::GLOBAL_GATE_BIT];
            end
            if (zd_hit) begin
                zd_sel_q <= reg_wdata[2:0];
            end
        end
    end

    // read mux
    // registered below so reg_rdata comes straight from a flop
    always_comb begin
        rdata_d = 8'h00;
        for (int i = 0; i < ND; i++) begin
            if (gate_hit[i]) begin
                rdata_d = gate_q[i];
            end
            if (cfg_hit[i]) begin
                rdata_d = cfg_q[i];
            end
            if (sel_hit[i]) begin
                rdata_d = sel_q[i];
            end
        end
        if (global_hit) begin
            rdata_d = {7'h00, global_gate_q};
        end
        if (zd_hit) begin
            rdata_d = {5'h00, zd_sel_q};
        end
        if (rst_hit) begin
            rdata_d = {6'h00, (rst_state_q != ocrg_pkg::RST_IDLE), 1'b0};
        end
        if (stat_lo_hit) begin
            rdata_d = drv_active[7:0];
        end
        if (stat_hi_hit) begin
            rdata_d = {4'h0, zd_active, (rst_state_q != ocrg_pkg::RST_IDLE), drv_active[9:8]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // feedback path: internal loop opened in zero-delay mode
    // external feedback passes two synchroniser stages before this one, internal feedback only this one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fb_q <= 1'b0;
            fb_sel_q <= 1'b0;
        end else begin
            fb_sel_q <= zd_active; // RQ9
            fb_q <= zd_active ? fb_ext_lvl : internal_feedback; // RQ9
        end
    end

    // hard reset request: falling pin edge or self-clearing register bit
    assign pin_req = rst_pin_prev_q & ~rst_pin_lvl;
    assign reg_req = reg_wr & rst_hit & reg_wdata[ocrg_pkg::HARD_RESET_BIT];
    assign reset_req = pin_req | reg_req;

    always_comb begin
        rst_state_d = rst_state_q;
        rst_cnt_d = rst_cnt_q;
        case (rst_state_q)
            ocrg_pkg::RST_IDLE: begin
                // loaded one short: the zero count still spends a cycle waiting
                if (reset_req && zd_active) begin
                    rst_state_d = ocrg_pkg::RST_WAIT;
                    rst_cnt_d = 28'(HARD_RESET_DELAY_CYC - 1); // RQ10
                end else if (reset_req) begin
                    rst_state_d = ocrg_pkg::RST_FIRE;
                end
            end
            ocrg_pkg::RST_WAIT: begin
                // further requests during the hold-off merge into this one
                if (rst_cnt_q == 28'h0000000) begin
                    rst_state_d = ocrg_pkg::RST_FIRE; // RQ10
                end else begin
                    rst_cnt_d = rst_cnt_q - 28'h0000001;
                end
            end
            ocrg_pkg::RST_FIRE: begin
                rst_state_d = ocrg_pkg::RST_IDLE;
            end
            default: begin
                rst_state_d = ocrg_pkg::RST_IDLE;
            end
        endcase
    end

    // exec leaves with fire, so the reload lands on the following edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rst_state_q <= ocrg_pkg::RST_IDLE;
            rst_cnt_q <= 28'h0000000;
            rst_pin_prev_q <= 1'b1;
            exec_q <= 1'b0;
        end else begin
            rst_state_q <= rst_state_d;
            rst_cnt_q <= rst_cnt_d;
            rst_pin_prev_q <= rst_pin_lvl;
            exec_q <= (rst_state_d == ocrg_pkg::RST_FIRE);
        end
    end

    assign reg_rdata = rdata_q;
    assign loop_feedback = fb_q;
    assign feedback_external_sel = fb_sel_q;
    assign hard_reset_exec = exec_q;
endmodule
`default_nettype wire

// [bench/ocrg_sva.sv]
/*
 * ocrg_sva: port assertions for ocrg_top.
 * assumes one clk_sys domain and that reset requests do not overlap.
 */
`timescale 1ns/1ps
`default_nettype none
module ocrg_sva #(
    parameter int HARD_RESET_DELAY_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] synth_clk,
    input wire logic hard_reset_pin_n,
    input wire logic output_disable_pin,
    input wire logic external_feedback_input,
    input wire logic internal_feedback,
    input wire logic [9:0] drv_out,
    input wire logic loop_feedback,
    input wire logic feedback_external_sel,
    input wire logic hard_reset_exec
);
    logic [31:0] wait_q;
    logic [5:0] dis_q;
    logic rst_req;
    assign rst_req = reg_wr && reg_addr == ocrg_pkg::RESET_CTRL_OFS
        && reg_wdata[ocrg_pkg::HARD_RESET_BIT];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // pin requests are not counted here, only register ones
    always_ff @(posedge clk_sys) begin
        if (!nrst || hard_reset_exec) wait_q <= 32'h0;
        else if (rst_req || wait_q != 32'h0) wait_q <= wait_q + 32'h1;
        if (!nrst || !output_disable_pin) dis_q <= 6'h0;
        else if (dis_q != 6'h3f) dis_q <= dis_q + 6'h1;
    end
    reset_prompt_a: assert property (
        rst_req && !hard_reset_exec && wait_q == 32'h0 && !feedback_external_sel
        |=> hard_reset_exec) else $error("hard reset not prompt");
    zd_hold_off_a: assert property (
        hard_reset_exec && feedback_external_sel |-> wait_q >= HARD_RESET_DELAY_CYC)
        else $error("zero delay reset too early");
    zd_wait_bound_a: assert property (wait_q <= HARD_RESET_DELAY_CYC + 4)
        else $error("zero delay reset too late");
    zd_enter_a: assert property (
        reg_wr && reg_addr == ocrg_pkg::ZERO_DELAY_OFS && reg_wdata[2:0] == 3'h3
        && !hard_reset_exec |-> ##[1:2] feedback_external_sel)
        else $error("zero delay not entered");
    fb_internal_a: assert property (
        !feedback_external_sel && !$past(feedback_external_sel) && $past(nrst)
        |-> loop_feedback == $past(internal_feedback)) else $error("feedback not internal");
    sel_readback_a: assert property (
        reg_wr && reg_addr == ocrg_pkg::SEL_OFS[0] && !hard_reset_exec ##1 !reg_wr
        && !hard_reset_exec ##1 reg_rd && reg_addr == ocrg_pkg::SEL_OFS[0]
        |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3)) else $error("select lost");
    reset_reload_a: assert property (
        hard_reset_exec ##1 reg_rd && reg_addr == ocrg_pkg::ZERO_DELAY_OFS
        |=> reg_rdata == 8'h04) else $error("reload missing");
    pin_off_a: assert property (dis_q == 6'h3f |=> $stable(drv_out))
        else $error("drivers run with disable pin high");
    cover property (hard_reset_exec && feedback_external_sel);
    cover property (dis_q == 6'h3f);
    cover property (reg_rd && reg_addr == ocrg_pkg::ZERO_DELAY_OFS);
endmodule
bind ocrg_top ocrg_sva #(.HARD_RESET_DELAY_CYC(HARD_RESET_DELAY_CYC)) u_sva (.*);
`default_nettype wire

// [bench/ocrg_board.sv]
/*
 * ocrg_board: board loads counting rising edges per driver, and the
 * feedback trace from driver nine. assumes drv_out is clk_sys timed.
 */
`timescale 1ns/1ps
`default_nettype none
module ocrg_board (
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic [9:0] drv_out,
    output logic external_feedback_input,
    output int edges [10]
);
    logic [9:0] last_q;
    // trace delay only; driver nine returns to the feedback input
    assign #2 external_feedback_input = drv_out[9];
    always @(posedge clk_sys) begin
        last_q <= drv_out;
        for (int i = 0; i < 10; i++) begin
            if (clr) edges[i] <= 0;
            else if (drv_out[i] && !last_q[i]) edges[i] <= edges[i] + 1;
        end
    end
endmodule
`default_nettype wire

// [bench/ocrg_top_tb.sv]
/*
 * ocrg_top_tb: self-checking bench for ocrg_top with the board model.
 * assumes a 20-cycle hold-off and synth clocks below clk_sys/2.
 */
`timescale 1ns/1ps
`default_nettype none
module ocrg_top_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic clr = 1'b1, hard_reset_pin_n = 1'b1, output_disable_pin = 1'b0;
    logic internal_feedback = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [7:0] reg_wdata = 8'h0;
    logic [4:0] synth_clk = 5'h0;
    logic [7:0] reg_rdata;
    logic [9:0] drv_out;
    logic external_feedback_input, loop_feedback, feedback_external_sel, hard_reset_exec;
    int edges [10];
    int n_errors = 0, samples_checked = 0, seed = 32'h56a4baf1;
    int cyc = 0, exec_at = -1;
    logic [7:0] exp_q [$];
    logic [2:0] sel [10];
    always #2.5 clk_sys = ~clk_sys;
    // source periods 6, 10, 14, 18, 22 clk_sys cycles
    for (genvar k = 0; k < 5; k++) begin : g_syn
        always #(15.0 + 10.0 * k) synth_clk[k] = ~synth_clk[k];
    end
    ocrg_top #(.HARD_RESET_DELAY_CYC(20)) DUT (.*);
    ocrg_board board (.*);
    always @(posedge clk_sys) internal_feedback <= #1 1'($random(seed));
    always @(posedge clk_sys) rd_d <= reg_rd;
    // the reset pulse can pass inside a write task, so its cycle is kept here
    always @(posedge clk_sys) cyc <= cyc + 1;
    always @(negedge clk_sys) if (hard_reset_exec === 1'b1) exec_at = cyc;
    always @(negedge clk_sys) begin
        if (rd_d) begin
            if (exp_q.size() == 0) chk("read queue", 1, 0);
            else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    // idle cycle after each access keeps strobes from re-asserting in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        tick();
    endtask
    task automatic measure(input logic [9:0] on);
        int e;
        repeat (100) tick();
        clr = 1'b1;
        tick();
        clr = 1'b0;
        repeat (880) tick();
        for (int i = 0; i < 10; i++) begin
            e = (on[i] && sel[i] < 5) ? 880 / (12 + 8 * sel[i]) : 0;
            chk("edge count", 1, e == 0 ? edges[i] == 0 : edges[i] - e inside {[-1:1]});
        end
    endtask
    task automatic up0();
        int n = 0;
        while (drv_out[0] !== 1'b0 && n < 50) begin
            tick();
            n++;
        end
        while (drv_out[0] !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        if (n >= 100) begin
            chk("driver0 rise", 1, 0);
            complete_run();
        end
    endtask
    // delay counted in cycles from the request stamp t0
    task automatic wait_exec(input int t0, input int lo, input int hi);
        int n = 0;
        int d;
        while (hard_reset_exec !== 1'b1 && exec_at <= t0 && n <= hi) begin
            tick();
            n++;
        end
        d = (hard_reset_exec === 1'b1) ? cyc - t0 : exec_at - t0;
        chk("reset delay", 1, d > 0 && d >= lo && d <= hi);
        if (d <= 0) complete_run();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        int r;
        int t0;
        int n;
        repeat (8) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        tick();
        for (int i = 0; i < 10; i++) begin
            rd(ocrg_pkg::CFG_OFS[i], 8'h08);
            rd(ocrg_pkg::SEL_OFS[i], 8'h00);
        end
        rd(ocrg_pkg::GLOBAL_GATE_OFS, 8'h01);
        rd(ocrg_pkg::ZERO_DELAY_OFS, 8'h04);
        rd(16'h0200, 8'h00);
        for (int p = 0; p < 2; p++) begin
            r = $random(seed);
            for (int i = 0; i < 10; i++) begin
                sel[i] = 3'(i + r);
                wr(ocrg_pkg::SEL_OFS[i], {5'h0, sel[i]});
                rd(ocrg_pkg::SEL_OFS[i], {5'h0, sel[i]});
            end
            measure(10'h3ff);
        end
        for (int i = 0; i < 10; i += 2) wr(ocrg_pkg::GATE_OFS[i], 8'h00);
        wr(ocrg_pkg::CFG_OFS[0], 8'h18);
        measure(10'h2aa);
        chk("disabled levels", 2'b01, {drv_out[2], drv_out[0]});
        for (int i = 2; i < 10; i += 2) wr(ocrg_pkg::GATE_OFS[i], 8'h02);
        wr(ocrg_pkg::GLOBAL_GATE_OFS, 8'h00);
        measure(10'h000);
        wr(ocrg_pkg::GLOBAL_GATE_OFS, 8'h01);
        output_disable_pin = 1'b1;
        measure(10'h000);
        output_disable_pin = 1'b0;
        wr(ocrg_pkg::SEL_OFS[0], 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(ocrg_pkg::CFG_OFS[0], m ? 8'h00 : 8'h08);
            repeat (3'($random(seed))) tick();
            wr(ocrg_pkg::GATE_OFS[0], 8'h02);
            up0();
            n = 0;
            while (drv_out[0] === 1'b1 && n < 40) begin
                tick();
                n++;
            end
            if (m == 0) chk("first pulse", 6, n);
            up0();
            wr(ocrg_pkg::GATE_OFS[0], 8'h00);
            tick();
            chk("early level", m ? 0 : 1, drv_out[0]);
            repeat (30) tick();
            chk("late level", 0, drv_out[0]);
        end
        wr(ocrg_pkg::CFG_OFS[9], 8'h18);
        wr(ocrg_pkg::GATE_OFS[9], 8'h00);
        // host side: comparison rate taken as above the zero-delay floor
        wr(ocrg_pkg::ZERO_DELAY_OFS, 8'h03);
        rd(ocrg_pkg::ZERO_DELAY_OFS, 8'h03);
        repeat (60) tick();
        chk("feedback select", 1, feedback_external_sel);
        chk("loop feedback", 1, loop_feedback);
        t0 = cyc;
        wr(ocrg_pkg::RESET_CTRL_OFS, 8'h02);
        wait_exec(t0, 19, 21);
        tick();
        rd(ocrg_pkg::ZERO_DELAY_OFS, 8'h04);
        rd(ocrg_pkg::CFG_OFS[0], 8'h08);
        t0 = cyc;
        wr(ocrg_pkg::RESET_CTRL_OFS, 8'h02);
        wait_exec(t0, 0, 2);
        t0 = cyc;
        hard_reset_pin_n = 1'b0;
        wait_exec(t0, 0, 8);
        hard_reset_pin_n = 1'b1;
        repeat (4) tick();
        complete_run();
    end
endmodule
`default_nettype wire
